// ==== rtl/srt_slot_remap.sv ====
// Slot remapping table: record store, validation and I/O slot translation.
`timescale 1ns/100ps
module srt_slot_remap (
  // Clock, reset and enable
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  // Configuration and startup check
  input wire logic free_slot_remapping_i,
  input wire logic cfg_mismatch_i,
  output logic cfg_mismatch_o,
  output logic map_valid_o,
  output logic [63:0] slot_active_o,
  // Record write stream
  input wire logic wr_vld_i,
  input wire logic wr_first_i,
  input wire logic [7:0] wr_byte_i,
  output logic wr_ready_o,
  output logic wr_done_o,
  output logic wr_reject_o,
  // Record read
  input wire logic rd_req_i,
  input wire logic [srt_pkg::SRT_IDX_W-1:0] rd_idx_i,
  output logic rd_ack_o,
  output logic [7:0] rd_data_o,
  // Retentive storage
  output logic nv_rd_en_o,
  output logic [srt_pkg::SRT_IDX_W-1:0] nv_rd_addr_o,
  input wire logic [7:0] nv_rd_data_i,
  output logic nv_wr_en_o,
  output logic [srt_pkg::SRT_IDX_W-1:0] nv_wr_addr_o,
  output logic [7:0] nv_wr_data_o,
  // Target-side I/O access
  input wire logic io_req_i,
  input wire logic io_wr_i,
  input wire logic [srt_pkg::SRT_IDX_W-1:0] io_slot_i,
  input wire logic [7:0] io_wdata_i,
  output logic io_ack_o,
  output logic [7:0] io_rdata_o,
  // Physical-side I/O access
  output logic phys_req_o,
  output logic phys_wr_o,
  output logic [srt_pkg::SRT_IDX_W-1:0] phys_slot_o,
  output logic [7:0] phys_wdata_o,
  input wire logic [7:0] phys_rdata_i
);
  import srt_pkg::*;

  // ==========================================================================
  // Storage and state
  // 64 byte entries
  logic [7:0] active_q [SRT_SLOT_CNT];
  logic [7:0] shadow_q [SRT_SLOT_CNT];
  srt_state_t state_q;
  srt_state_t state_d;
  logic [SRT_CNT_W-1:0] ld_cnt_q;
  logic [SRT_CNT_W-1:0] wr_cnt_q;
  logic [SRT_CNT_W-1:0] st_cnt_q;
  logic wr_open_q;
  logic fin_wr_q;
  logic fin_ld_q;
  logic map_valid_q;
  logic remap_on;
  logic chk_clear;
  logic chk_vld;
  logic [7:0] chk_byte;
  logic [5:0] chk_idx;
  logic chk_bad;
  logic chk_diff;
  logic wr_take;
  logic ld_take;
  logic [63:0] act_d;
  srt_kind_t io_kind;
  logic [7:0] io_entry;
  logic s1_vld_q;
  logic s1_route_q;
  logic s1_wr_q;

  // ==========================================================================
  // Functions
  // Classify one entry value.
  function automatic srt_kind_t entry_kind(input logic [7:0] v);
    srt_kind_t k;
    if (v == SRT_MAP_IGNORE) begin
      k = SRT_K_IGNORE;
    end else if (v <= SRT_MAP_SLOT_MAX) begin
      k = SRT_K_SLOT;
    end else if (v == SRT_MAP_VIRTUAL) begin
      k = SRT_K_VIRTUAL;
    end else begin
      k = SRT_K_BAD;
    end
    return k;
  endfunction

  // Entry in force for a target slot: stored entry, or identity when off.
  function automatic logic [7:0] eff_entry(input logic on, input logic [7:0] stored,
                                           input logic [5:0] idx);
    logic [7:0] e;
    e = on ? stored : (8'({2'b00, idx}) + SRT_MAP_SLOT_MIN);
    return e;
  endfunction

  assign remap_on = free_slot_remapping_i && map_valid_q;

  // ==========================================================================
  // Sequencer: load from retentive storage, serve writes, commit changes.
  always_comb begin
    state_d = state_q;
    case (state_q)
      SRT_ST_LOAD: begin
        if (fin_ld_q) begin
          state_d = SRT_ST_IDLE;
        end
      end
      SRT_ST_IDLE: begin
        if (fin_wr_q && !chk_bad && chk_diff) begin
          state_d = SRT_ST_STORE;
        end
      end
      SRT_ST_STORE: begin
        if (st_cnt_q == SRT_REC_LAST) begin
          state_d = SRT_ST_IDLE;
        end
      end
      default: begin
        state_d = SRT_ST_LOAD;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      state_q <= SRT_ST_LOAD;
      wr_ready_o <= 1'b0;
    end else if (clk_en_i) begin
      state_q <= state_d;
      // Writes are refused while storage is busy so a record cannot be torn.
      wr_ready_o <= (state_d == SRT_ST_IDLE);
    end
  end

  // ==========================================================================
  // Checker feed: loaded bytes arrive in the cycle their address is presented, when ld_cnt_q is already one ahead.
  assign ld_take = (state_q == SRT_ST_LOAD) && (ld_cnt_q != SRT_CNT_RST) && !fin_ld_q;
  assign wr_take = wr_ready_o && wr_vld_i && (wr_first_i || wr_open_q);
  assign chk_vld = ld_take || wr_take;
  assign chk_byte = ld_take ? nv_rd_data_i : wr_byte_i;
  assign chk_idx = ld_take ? 6'(ld_cnt_q - 7'h01) : (wr_first_i ? 6'h00 : 6'(wr_cnt_q));
  assign chk_clear = (ld_take && (ld_cnt_q == 7'h01)) || (wr_take && wr_first_i);

  srt_record_check u_check (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .clk_en_i(clk_en_i),
    .clear_i(chk_clear),
    .byte_vld_i(chk_vld),
    .byte_i(chk_byte),
    .cur_byte_i(active_q[chk_idx]),
    .bad_o(chk_bad),
    .diff_o(chk_diff)
  );

  // ==========================================================================
  // Retentive load after reset.
  // restore record
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ld_cnt_q <= SRT_CNT_RST;
      nv_rd_en_o <= 1'b0;
      nv_rd_addr_o <= '0;
      fin_ld_q <= 1'b0;
    end else if (clk_en_i) begin
      fin_ld_q <= ld_take && (ld_cnt_q == SRT_REC_LEN);
      if ((state_q == SRT_ST_LOAD) && (ld_cnt_q != SRT_REC_LEN)) begin
        nv_rd_en_o <= 1'b1;
        nv_rd_addr_o <= 6'(ld_cnt_q);
        ld_cnt_q <= ld_cnt_q + 7'h01;
      end else begin
        nv_rd_en_o <= 1'b0;
        if (ld_take) begin
          ld_cnt_q <= ld_cnt_q + 7'h01;
        end
      end
    end
  end

  // ==========================================================================
  // Write framing: a record is only judged once all 64 bytes have arrived.
  // whole record only
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wr_cnt_q <= SRT_CNT_RST;
      wr_open_q <= 1'b0;
      fin_wr_q <= 1'b0;
    end else if (clk_en_i) begin
      fin_wr_q <= wr_take && (6'(chk_idx) == 6'(SRT_REC_LAST));
      if (wr_take) begin
        wr_cnt_q <= 7'(chk_idx) + 7'h01;
        wr_open_q <= (7'(chk_idx) != SRT_REC_LAST);
      end
    end
  end

  // Shadow collects incoming bytes; a new first byte restarts a partial frame.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < SRT_SLOT_CNT; i++) begin
        shadow_q[i] <= SRT_ENTRY_RST;
      end
    end else if (clk_en_i && chk_vld) begin
      shadow_q[chk_idx] <= chk_byte;
    end
  end

  // ==========================================================================
  // Active mapping and verdict reporting.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < SRT_SLOT_CNT; i++) begin
        active_q[i] <= SRT_ENTRY_RST;
      end
      map_valid_q <= 1'b0;
      wr_done_o <= 1'b0;
      wr_reject_o <= 1'b0;
    end else if (clk_en_i) begin
      wr_done_o <= fin_wr_q && !chk_bad;
      wr_reject_o <= fin_wr_q && chk_bad;
      if ((fin_wr_q || fin_ld_q) && !chk_bad) begin
        for (int i = 0; i < SRT_SLOT_CNT; i++) begin
          active_q[i] <= shadow_q[i];
        end
        map_valid_q <= 1'b1;
      end else if (fin_ld_q) begin
        // A corrupt stored record leaves remapping off until a valid write.
        map_valid_q <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Commit to retentive storage, one byte per cycle.
  // store when differs
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st_cnt_q <= SRT_CNT_RST;
      nv_wr_en_o <= 1'b0;
      nv_wr_addr_o <= '0;
      nv_wr_data_o <= SRT_DATA_RST;
    end else if (clk_en_i) begin
      nv_wr_en_o <= (state_q == SRT_ST_STORE);
      nv_wr_addr_o <= 6'(st_cnt_q);
      nv_wr_data_o <= active_q[6'(st_cnt_q)];
      st_cnt_q <= (state_q == SRT_ST_STORE) ? (st_cnt_q + 7'h01) : SRT_CNT_RST;
    end
  end

  // ==========================================================================
  // Record read-back of the active mapping.
  // partial read
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      rd_ack_o <= 1'b0;
      rd_data_o <= SRT_DATA_RST;
    end else if (clk_en_i) begin
      rd_ack_o <= rd_req_i;
      if (rd_req_i) begin
        rd_data_o <= active_q[rd_idx_i];
      end
    end
  end

  // ==========================================================================
  // Status: startup mismatch masking and physical slot activity.
  always_comb begin
    for (int p = 0; p < SRT_SLOT_CNT; p++) begin
      act_d[p] = !remap_on;
      for (int t = 0; t < SRT_SLOT_CNT; t++) begin
        if (remap_on && (entry_kind(active_q[t]) == SRT_K_SLOT) &&
            (active_q[t] == (8'(p) + SRT_MAP_SLOT_MIN))) begin
          act_d[p] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      cfg_mismatch_o <= 1'b0;
      map_valid_o <= 1'b0;
      slot_active_o <= 64'h0;
    end else if (clk_en_i) begin
      cfg_mismatch_o <= cfg_mismatch_i && !remap_on;
      map_valid_o <= map_valid_q;
      slot_active_o <= act_d;
    end
  end

  // ==========================================================================
  // I/O translation: stage one issues the physical access, stage two answers.
  assign io_entry = eff_entry(remap_on, active_q[io_slot_i], io_slot_i);
  assign io_kind = entry_kind(io_entry);

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      s1_vld_q <= 1'b0;
      s1_route_q <= 1'b0;
      s1_wr_q <= 1'b0;
      phys_req_o <= 1'b0;
      phys_wr_o <= 1'b0;
      phys_slot_o <= '0;
      phys_wdata_o <= SRT_DATA_RST;
    end else if (clk_en_i) begin
      s1_vld_q <= io_req_i;
      s1_wr_q <= io_wr_i;
      s1_route_q <= io_req_i && (io_kind == SRT_K_SLOT);
      phys_req_o <= io_req_i && (io_kind == SRT_K_SLOT);
      phys_wr_o <= io_req_i && io_wr_i && (io_kind == SRT_K_SLOT);
      if (io_req_i && (io_kind == SRT_K_SLOT)) begin
        phys_slot_o <= 6'(io_entry - SRT_MAP_SLOT_MIN);
        phys_wdata_o <= io_wdata_i;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      io_ack_o <= 1'b0;
      io_rdata_o <= SRT_DATA_RST;
    end else if (clk_en_i) begin
      io_ack_o <= s1_vld_q;
      io_rdata_o <= (s1_route_q && !s1_wr_q) ? phys_rdata_i : SRT_DATA_RST;
    end
  end

endmodule

// ==== common/srt_pkg.sv ====
// Constants and types shared by the slot remapping table design.
package srt_pkg;

  // ==========================================================================
  // Record geometry
  localparam int unsigned SRT_SLOT_CNT = 64;
  localparam int unsigned SRT_IDX_W = 6;
  localparam int unsigned SRT_CNT_W = 7;
  localparam logic [6:0] SRT_REC_LAST = 7'h3F;
  localparam logic [6:0] SRT_REC_LEN = 7'h40;

  // ==========================================================================
  // Entry encodings
  localparam logic [7:0] SRT_MAP_IGNORE = 8'h00;
  localparam logic [7:0] SRT_MAP_SLOT_MIN = 8'h01;
  localparam logic [7:0] SRT_MAP_SLOT_MAX = 8'h40;
  localparam logic [7:0] SRT_MAP_VIRTUAL = 8'hFF;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] SRT_ENTRY_RST = 8'h00;
  localparam logic [7:0] SRT_DATA_RST = 8'h00;
  localparam logic [6:0] SRT_CNT_RST = 7'h00;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    SRT_ST_LOAD  = 3'b001,
    SRT_ST_IDLE  = 3'b010,
    SRT_ST_STORE = 3'b100
  } srt_state_t;

  typedef enum logic [1:0] {
    SRT_K_IGNORE  = 2'h0,
    SRT_K_SLOT    = 2'h1,
    SRT_K_VIRTUAL = 2'h2,
    SRT_K_BAD     = 2'h3
  } srt_kind_t;

endpackage

// ==== rtl/srt_record_check.sv ====
// Streaming validity and difference check of one mapping record.
`timescale 1ns/100ps
module srt_record_check (
  // Clock, reset and enable
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic clk_en_i,
  // Byte stream
  input wire logic clear_i,
  input wire logic byte_vld_i,
  input wire logic [7:0] byte_i,
  input wire logic [7:0] cur_byte_i,
  // Verdict
  output logic bad_o,
  output logic diff_o
);
  import srt_pkg::*;

  logic [63:0] seen_q;
  logic [63:0] seen_base;
  logic bad_base;
  logic diff_base;
  logic in_range;
  logic range_bad;
  logic dup;
  logic [5:0] slot_idx;

  // ==========================================================================
  // Byte classification
  // A clear in the same cycle as a byte starts a fresh record with that byte.
  always_comb begin
    seen_base = clear_i ? 64'h0 : seen_q;
    bad_base = clear_i ? 1'b0 : bad_o;
    diff_base = clear_i ? 1'b0 : diff_o;
    in_range = (byte_i >= SRT_MAP_SLOT_MIN) && (byte_i <= SRT_MAP_SLOT_MAX);
    slot_idx = 6'(byte_i - SRT_MAP_SLOT_MIN);
    range_bad = (byte_i > SRT_MAP_SLOT_MAX) && (byte_i != SRT_MAP_VIRTUAL);
    dup = in_range && seen_base[slot_idx];
  end

  // ==========================================================================
  // Accumulated verdict; a whole record is judged, never a single byte.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      seen_q <= 64'h0;
      bad_o <= 1'b0;
      diff_o <= 1'b0;
    end else if (clk_en_i) begin
      if (byte_vld_i) begin
        seen_q <= seen_base | (in_range ? (64'h1 << slot_idx) : 64'h0);
        bad_o <= bad_base | range_bad | dup;
        diff_o <= diff_base | (byte_i != cur_byte_i);
      end else if (clear_i) begin
        seen_q <= 64'h0;
        bad_o <= 1'b0;
        diff_o <= 1'b0;
      end
    end
  end

endmodule

// ==== sim/srt_slot_remap_chk.sv ====
// Port checker for the slot remapping table.
`timescale 1ns/100ps
module srt_slot_remap_chk (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Configuration
  input wire logic free_slot_remapping_i,
  input wire logic cfg_mismatch_i,
  input wire logic cfg_mismatch_o,
  input wire logic map_valid_o,
  input wire logic [63:0] slot_active_o,
  // Record and storage
  input wire logic wr_done_o,
  input wire logic wr_reject_o,
  input wire logic rd_req_i,
  input wire logic rd_ack_o,
  input wire logic nv_wr_en_o,
  // Slot access
  input wire logic io_req_i,
  input wire logic io_wr_i,
  input wire logic [5:0] io_slot_i,
  input wire logic [7:0] io_wdata_i,
  input wire logic io_ack_o,
  input wire logic phys_req_o,
  input wire logic phys_wr_o,
  input wire logic [5:0] phys_slot_o,
  input wire logic [7:0] phys_wdata_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  // ==========================================================
  // Properties
  property p_rd_ack; rd_req_i |=> rd_ack_o; endproperty
  property p_io_ack; io_req_i |-> ##2 io_ack_o; endproperty
  property p_thru; !free_slot_remapping_i && io_req_i |=> phys_req_o && phys_slot_o == $past(io_slot_i); endproperty
  property p_no_stray; phys_req_o |-> $past(io_req_i); endproperty
  property p_wr_data; phys_req_o |-> phys_wr_o == $past(io_wr_i) && phys_wdata_o == $past(io_wdata_i); endproperty
  // The $past guard skips the first edge after reset, where old inputs are still seen.
  property p_mis; $past(rst_n_i) |-> cfg_mismatch_o == ($past(cfg_mismatch_i) &&
    !($past(free_slot_remapping_i) && map_valid_o)); endproperty
  property p_excl; !(wr_done_o && wr_reject_o); endproperty
  property p_store; $rose(nv_wr_en_o) |-> $past(wr_done_o); endproperty
  property p_rej; wr_reject_o |=> !nv_wr_en_o [*8]; endproperty
  property p_all_on; (!free_slot_remapping_i) [*3] |-> slot_active_o == {64{1'b1}}; endproperty

  // ==========================================================
  // Assertions
  a_rd_ack: assert property (p_rd_ack) else $error("read not answered");
  a_io_ack: assert property (p_io_ack) else $error("access not answered");
  a_thru: assert property (p_thru) else $error("straight mapping broken");
  a_no_stray: assert property (p_no_stray) else $error("physical access without request");
  a_wr_data: assert property (p_wr_data) else $error("physical write data wrong");
  a_mis: assert property (p_mis) else $error("startup mismatch flag wrong");
  a_excl: assert property (p_excl) else $error("done and reject together");
  a_store: assert property (p_store) else $error("store without accepted record");
  a_rej: assert property (p_rej) else $error("rejected record stored");
  a_all_on: assert property (p_all_on) else $error("slots not all active");
  c_done: cover property (wr_done_o);
  c_rej: cover property (wr_reject_o);
  c_phys_rd: cover property (phys_req_o && !phys_wr_o);
endmodule
bind srt_slot_remap srt_slot_remap_chk srt_slot_remap_chk_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
  .free_slot_remapping_i(free_slot_remapping_i), .cfg_mismatch_i(cfg_mismatch_i), .cfg_mismatch_o(cfg_mismatch_o),
  .map_valid_o(map_valid_o), .slot_active_o(slot_active_o), .wr_done_o(wr_done_o), .wr_reject_o(wr_reject_o),
  .rd_req_i(rd_req_i), .rd_ack_o(rd_ack_o), .nv_wr_en_o(nv_wr_en_o), .io_req_i(io_req_i), .io_wr_i(io_wr_i),
  .io_slot_i(io_slot_i), .io_wdata_i(io_wdata_i), .io_ack_o(io_ack_o), .phys_req_o(phys_req_o),
  .phys_wr_o(phys_wr_o), .phys_slot_o(phys_slot_o), .phys_wdata_o(phys_wdata_o));

// ==== sim/srt_far_model.sv ====
// Storage and physical slot model facing the remapping table.
`timescale 1ns/100ps
module srt_far_model (
  // Clock
  input wire logic sys_clk_i,
  // Retentive storage
  input wire logic nv_rd_en_i,
  input wire logic [5:0] nv_rd_addr_i,
  output logic [7:0] nv_rd_data_o,
  input wire logic nv_wr_en_i,
  input wire logic [5:0] nv_wr_addr_i,
  input wire logic [7:0] nv_wr_data_i,
  output int nv_wr_cnt_o,
  // Physical slots
  input wire logic phys_req_i,
  input wire logic phys_wr_i,
  input wire logic [5:0] phys_slot_i,
  input wire logic [7:0] phys_wdata_i,
  output logic [7:0] phys_rdata_o,
  output logic [13:0] phys_last_o
);
  logic [7:0] mem_q [64];
  logic [7:0] tick_q;
  // Storage starts with a straight mapping and is never cleared by reset.
  // content kept
  initial begin
    for (int i = 0; i < 64; i++) mem_q[i] = 8'(i + 1);
    nv_wr_cnt_o = 0;
    phys_last_o = 14'h0000;
    tick_q = 8'h00;
  end
  // Read data stands in the cycle the address is presented, as the table samples it at the next edge.
  // Outside a read a moving pattern shows, so stale data cannot pass.
  assign nv_rd_data_o = nv_rd_en_i ? mem_q[nv_rd_addr_i] : ~tick_q;
  always @(posedge sys_clk_i) begin
    tick_q <= tick_q + 8'h01;
    if (nv_wr_en_i) begin
      mem_q[nv_wr_addr_i] <= nv_wr_data_i;
      nv_wr_cnt_o <= nv_wr_cnt_o + 1;
    end
    if (phys_req_i && phys_wr_i) phys_last_o <= {phys_slot_i, phys_wdata_i};
  end
  // A physical slot answers with a tag of its own index, otherwise a moving pattern.
  assign phys_rdata_o = phys_req_i ? {2'b10, phys_slot_i} : tick_q;
endmodule

// ==== sim/srt_slot_remap_bench.sv ====
// Self-checking testbench of the slot remapping table.
`timescale 1ns/100ps
module srt_slot_remap_bench;
  import srt_pkg::*;
  logic sys_clk_i = 1'b0, rst_n_i = 1'b0, clk_en_i = 1'b1, free_slot_remapping_i = 1'b0, cfg_mismatch_i = 1'b0;
  logic wr_vld_i = 1'b0, wr_first_i = 1'b0, rd_req_i = 1'b0, io_req_i = 1'b0, io_wr_i = 1'b0;
  logic [7:0] wr_byte_i = 8'h00, io_wdata_i = 8'h00, nv_rd_data_i, phys_rdata_i, rd_data_o, io_rdata_o;
  logic [5:0] rd_idx_i = 6'h00, io_slot_i = 6'h00, nv_rd_addr_o, nv_wr_addr_o, phys_slot_o;
  logic cfg_mismatch_o, map_valid_o, wr_ready_o, wr_done_o, wr_reject_o, rd_ack_o, nv_rd_en_o, nv_wr_en_o;
  logic io_ack_o, phys_req_o, phys_wr_o;
  logic [63:0] slot_active_o;
  logic [7:0] nv_wr_data_o, phys_wdata_o;
  logic [13:0] phys_last;
  logic [9:0] exp_q [$];
  logic [9:0] got;
  logic [5:0] rs;
  logic [7:0] rec [64];
  int nv_cnt, err_count = 0, cmp_count = 0, cyc = 0, seed = 32'h8EBD;

  srt_slot_remap srt_slot_remap_i (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .clk_en_i(clk_en_i),
    .free_slot_remapping_i(free_slot_remapping_i), .cfg_mismatch_i(cfg_mismatch_i), .cfg_mismatch_o(cfg_mismatch_o),
    .map_valid_o(map_valid_o), .slot_active_o(slot_active_o), .wr_vld_i(wr_vld_i), .wr_first_i(wr_first_i),
    .wr_byte_i(wr_byte_i), .wr_ready_o(wr_ready_o), .wr_done_o(wr_done_o), .wr_reject_o(wr_reject_o),
    .rd_req_i(rd_req_i), .rd_idx_i(rd_idx_i), .rd_ack_o(rd_ack_o), .rd_data_o(rd_data_o), .nv_rd_en_o(nv_rd_en_o),
    .nv_rd_addr_o(nv_rd_addr_o), .nv_rd_data_i(nv_rd_data_i), .nv_wr_en_o(nv_wr_en_o), .nv_wr_addr_o(nv_wr_addr_o),
    .nv_wr_data_o(nv_wr_data_o), .io_req_i(io_req_i), .io_wr_i(io_wr_i), .io_slot_i(io_slot_i),
    .io_wdata_i(io_wdata_i), .io_ack_o(io_ack_o), .io_rdata_o(io_rdata_o), .phys_req_o(phys_req_o),
    .phys_wr_o(phys_wr_o), .phys_slot_o(phys_slot_o), .phys_wdata_o(phys_wdata_o), .phys_rdata_i(phys_rdata_i));
  srt_far_model srt_far_model_i (.sys_clk_i(sys_clk_i), .nv_rd_en_i(nv_rd_en_o), .nv_rd_addr_i(nv_rd_addr_o),
    .nv_rd_data_o(nv_rd_data_i), .nv_wr_en_i(nv_wr_en_o), .nv_wr_addr_i(nv_wr_addr_o), .nv_wr_data_i(nv_wr_data_o),
    .nv_wr_cnt_o(nv_cnt), .phys_req_i(phys_req_o), .phys_wr_i(phys_wr_o), .phys_slot_i(phys_slot_o),
    .phys_wdata_i(phys_wdata_o), .phys_rdata_o(phys_rdata_i), .phys_last_o(phys_last));

  // ==========================================================
  // Clock and hang guard
  always #5 sys_clk_i = ~sys_clk_i;
  // A run needs about 700 cycles, so 6000 means a hang.
  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      err_count++;
      results();
    end
  end

  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [13:0] g, input logic [13:0] e);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("FAIL %0t got %h expected %h", $time, g, e);
    end
  endtask

  // ==========================================================
  // Drivers; each notes its expected answer first
  task automatic io(input logic w, input logic [5:0] s, input logic [7:0] d, input logic [7:0] e);
    exp_q.push_back({2'h0, e});
    @(posedge sys_clk_i);
    io_req_i <= 1'b1;
    io_wr_i <= w;
    io_slot_i <= s;
    io_wdata_i <= d;
    cfg_mismatch_i <= 1'($random(seed));
    @(posedge sys_clk_i);
    io_req_i <= 1'b0;
  endtask
  task automatic rd(input logic [5:0] i, input logic [7:0] e);
    exp_q.push_back({2'h1, e});
    @(posedge sys_clk_i);
    rd_req_i <= 1'b1;
    rd_idx_i <= i;
    @(posedge sys_clk_i);
    rd_req_i <= 1'b0;
  endtask
  task automatic wait_rdy();
    do @(posedge sys_clk_i); while (wr_ready_o !== 1'b1);
  endtask
  // The whole record always goes in one frame.
  // whole record
  task automatic send(input logic ok);
    exp_q.push_back(ok ? 10'h200 : 10'h300);
    wait_rdy();
    for (int i = 0; i < 64; i++) begin
      wr_vld_i <= 1'b1;
      wr_first_i <= (i == 0);
      wr_byte_i <= rec[i];
      @(posedge sys_clk_i);
    end
    wr_vld_i <= 1'b0;
    repeat (4) @(posedge sys_clk_i);
    wait_rdy();
  endtask

  // ==========================================================
  // Answer monitor: oldest note against each answer
  always @(posedge sys_clk_i) begin
    if (io_ack_o === 1'b1 || rd_ack_o === 1'b1 || wr_done_o === 1'b1 || wr_reject_o === 1'b1) begin
      got = io_ack_o ? {2'h0, io_rdata_o} : rd_ack_o ? {2'h1, rd_data_o} : {wr_reject_o ? 2'h3 : 2'h2, 8'h00};
      if (exp_q.size() == 0) chk(14'(got), 14'h3FFF);
      else chk(14'(got), 14'(exp_q.pop_front()));
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    io(1'b0, 6'h04, 8'h00, 8'h84);
    io(1'b1, 6'h02, 8'h5A, 8'h00);
    repeat (3) @(posedge sys_clk_i);
    chk(phys_last, {6'h02, 8'h5A});
    wait_rdy();
    free_slot_remapping_i <= 1'b1;
    rd(6'h0A, 8'h0B);
    for (int i = 0; i < 64; i++) rec[i] = 8'(i + 1);
    rec[0] = 8'h02;
    rec[1] = SRT_MAP_SLOT_MIN;
    rec[2] = SRT_MAP_IGNORE;
    rec[3] = SRT_MAP_VIRTUAL;
    rec[63] = SRT_MAP_SLOT_MAX;
    send(1'b1);
    // Let the last storage write land before counting.
    @(posedge sys_clk_i);
    chk(14'(nv_cnt), 14'h0040);
    chk(14'({map_valid_o, slot_active_o[5:0]}), 14'h0073);
    io(1'b0, 6'h00, 8'h00, 8'h81);
    io(1'b0, 6'h02, 8'h00, 8'h00);
    io(1'b0, 6'h03, 8'h00, 8'h00);
    io(1'b1, 6'h03, 8'hA5, 8'h00);
    io(1'b0, 6'h3F, 8'h00, 8'hBF);
    repeat (3) @(posedge sys_clk_i);
    chk(phys_last, {6'h02, 8'h5A});
    io(1'b1, 6'h01, 8'hC3, 8'h00);
    repeat (3) @(posedge sys_clk_i);
    chk(phys_last, {6'h00, 8'hC3});
    rd(6'h03, SRT_MAP_VIRTUAL);
    rd(6'h02, SRT_MAP_IGNORE);
    send(1'b1);
    @(posedge sys_clk_i);
    chk(14'(nv_cnt), 14'h0040);
    // Bad values at both ends of the refused range, then a duplicate slot.
    foreach (rec[k]) if (k == 5) begin
      rec[5] = 8'h41;
      send(1'b0);
      rec[5] = 8'hFE;
      send(1'b0);
      rec[5] = 8'h02;
      send(1'b0);
      rec[5] = 8'h06;
    end
    rd(6'h00, 8'h02);
    for (int n = 0; n < 20; n++) begin
      // Slots 4..62 hold entry slot+1, so the physical index equals the target index.
      rs = 6'h04 + 6'($unsigned($random(seed)) % 59);
      io(1'b0, rs, 8'h00, {2'b10, rs});
    end
    repeat (4) @(posedge sys_clk_i);
    chk(14'(exp_q.size()), 14'h0000);
    // Restart: the stored record must come back from storage.
    rst_n_i <= 1'b0;
    repeat (16) @(posedge sys_clk_i);
    rst_n_i <= 1'b1;
    wait_rdy();
    rd(6'h03, SRT_MAP_VIRTUAL);
    io(1'b0, 6'h00, 8'h00, 8'h81);
    repeat (6) @(posedge sys_clk_i);
    chk(14'(exp_q.size()), 14'h0000);
    results();
  end
endmodule
